// ---- rtl/tai_pin_rate_regs.vh ----
// register offsets, field positions, reset values and divider ratios
// for the pin function and data rate block; definitions only
`ifndef TAI_PIN_RATE_REGS_VH
`define TAI_PIN_RATE_REGS_VH

// ********************
// register indices
// ********************
`define PFR_CTRL_IDX 8'h1e
`define SILICON_REV_IDX 8'h1f

// ********************
// control field positions
// ********************
`define ANT_FN_BIT 7
`define TXD_FN_BIT 6
`define TXCM_FN_BIT 5
`define SPARE_FN_BIT 4
`define TXC_IN_BIT 3
`define RATE_MSB 2
`define RATE_LSB 0

// ********************
// reset values
// ********************
`define PFR_CTRL_RST 8'h09
`define REV_RST 8'h5a

// ********************
// divider ratios (oversample clock = bit rate x 20)
// ********************
`define OVS_FACTOR 20
`define DIV_20 13'h0014
`define DIV_40 13'h0028
`define DIV_80 13'h0050
`define DIV_160 13'h00a0
`define DIV_200 13'h00c8
`define DIV_400 13'h0190
`define DIV_2000 13'h07d0
`define DIV_4000 13'h0fa0

// ********************
// transmit timing
// ********************
`define ELASTIC_DEPTH 16
`define EXT_START_BITS 8

`endif

// ---- rtl/tai_pin_rate.v ----
// pin function and data rate control for the transceiver attachment side
// assumes one REF_CLK domain, a synchronous register port, and pin
// inputs already synchronous to REF_CLK
//
// What this block does
// - antenna pin direction from function bits
// - tx data pin direction from function bits
// - tx command pin function from bits
// - internal select drives divided clock out
// - external select makes clock pin input
// - external clock inserts 16-bit elastic buffer
// - external clock delays first data 8 bits
// - low-clock rate codes divide 20..2000
// - high-clock rate codes divide 20..4000
// - receive pll clock is 20x bit rate
// - transmit machine clock equals bit rate
// - read-only 8-bit revision register
`timescale 1ns/1ps
`include "tai_pin_rate_regs.vh"

module tai_pin_rate #(
  parameter [7:0] REVISION = `REV_RST  // arbitrary value
) (
  input wire REF_CLK,
  input wire SRST,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire ANTENNA_PIN_ENABLE,
  input wire ANTENNA_SWITCHING_ENABLE,
  input wire ANTENNA_SELECT_VAL,
  input wire TX_DATA_PIN_ENABLE,
  input wire TX_COMMAND_PIN_ENABLE,
  input wire RECEIVE_COMMAND_ENABLE,
  input wire CARD_BUS_MODE,
  input wire HIGH_INPUT_CLOCK_FLAG,
  input wire TRANSMIT_START_BIT,
  input wire TX_BIT_IN,
  input wire TX_CMD_VAL,
  input wire [7:0] ALT_ADDR_HI,
  output wire ANTENNA_SELECT_PIN_O,
  output wire ANTENNA_SELECT_PIN_OE_N,
  output wire TX_DATA_PIN_O,
  output wire TX_DATA_PIN_OE_N,
  output wire TX_COMMAND_PIN_O,
  output wire TX_COMMAND_PIN_OE_N,
  input wire TX_CLOCK_PIN_I,
  output wire TX_CLOCK_PIN_O,
  output wire TX_CLOCK_PIN_OE_N,
  output reg PLL_OVS_TICK,
  output reg TX_BIT_TICK,
  output wire TX_BIT_REQ
);

  // ********************
  // registers
  // ********************
  reg [7:0] ctrl_r;
  wire ext_clk = ctrl_r[`TXC_IN_BIT];
  wire [2:0] rate_code = ctrl_r[`RATE_MSB:`RATE_LSB];

  // returns zero for a reserved code
  function [12:0] ratio_of;
    input [2:0] code;
    input hi;
    begin
      ratio_of = 13'h0000;
      if (!hi) begin
        case (code)
          3'h1: ratio_of = `DIV_20;
          3'h2: ratio_of = `DIV_40;
          3'h3: ratio_of = `DIV_80;
          3'h5: ratio_of = `DIV_200;
          3'h6: ratio_of = `DIV_2000;
          default: ratio_of = 13'h0000;
        endcase
      end else begin
        case (code)
          3'h0: ratio_of = `DIV_20;
          3'h1: ratio_of = `DIV_40;
          3'h2: ratio_of = `DIV_80;
          3'h3: ratio_of = `DIV_160;
          3'h5: ratio_of = `DIV_400;
          3'h6: ratio_of = `DIV_4000;
          default: ratio_of = 13'h0000;
        endcase
      end
    end
  endfunction

  // ********************
  // register decode
  // ********************
  // one compare for every strobe keeps the index decoding in one place
  function hit;
    input strobe;
    input [7:0] addr;
    input [7:0] idx;
    begin
      hit = strobe && (addr == idx);
    end
  endfunction

  wire wr_ctrl = hit(WR, ADDR, `PFR_CTRL_IDX);
  wire rd_ctrl = hit(RD, ADDR, `PFR_CTRL_IDX);
  wire rd_rev = hit(RD, ADDR, `SILICON_REV_IDX);

  always @(posedge REF_CLK) begin
    if (SRST) begin
      ctrl_r <= `PFR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= WDATA;
    end
  end

  // ********************
  // register read
  // ********************
  always @(posedge REF_CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else if (rd_ctrl) begin
      RDATA <= ctrl_r & ~(8'h01 << `SPARE_FN_BIT);
    end else if (rd_rev) begin
      RDATA <= REVISION;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ********************
  // rate divider
  // ********************
  // the oversample tick is divided by 20 again for the bit tick, so
  // the pll always sees exactly twenty ticks per bit
  reg [12:0] ratio_r;
  reg [8:0] ovs_cnt_r;
  reg [4:0] bit_cnt_r;
  reg txc_r;
  wire [12:0] new_ratio = ratio_of(rate_code, HIGH_INPUT_CLOCK_FLAG);
  wire [31:0] ovs_full = ratio_r / `OVS_FACTOR;
  // largest ratio over twenty still fits nine bits
  wire [8:0] ovs_div = ovs_full[8:0];

  always @(posedge REF_CLK) begin
    if (SRST) begin
      ratio_r <= 13'h0000;
      ovs_cnt_r <= 9'h000;
      bit_cnt_r <= 5'h00;
      PLL_OVS_TICK <= 1'b0;
      TX_BIT_TICK <= 1'b0;
      txc_r <= 1'b0;
    end else begin
      if (new_ratio != 13'h0000) begin
        ratio_r <= new_ratio;
      end
      PLL_OVS_TICK <= 1'b0;
      TX_BIT_TICK <= 1'b0;
      if (ratio_r == 13'h0000) begin
        ovs_cnt_r <= 9'h000;
        bit_cnt_r <= 5'h00;
      end else if (ovs_cnt_r >= ovs_div - 9'h001) begin
        ovs_cnt_r <= 9'h000;
        PLL_OVS_TICK <= 1'b1;
        if (bit_cnt_r == 5'd19) begin
          bit_cnt_r <= 5'h00;
          TX_BIT_TICK <= 1'b1;
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        // tx clock high for first half of the bit
        if (bit_cnt_r == 5'd19) begin
          txc_r <= 1'b1;
        end else if (bit_cnt_r == 5'd9) begin
          txc_r <= 1'b0;
        end
      end else begin
        ovs_cnt_r <= ovs_cnt_r + 9'h001;
      end
    end
  end

  assign TX_CLOCK_PIN_O = txc_r;
  assign TX_CLOCK_PIN_OE_N = ext_clk;

  // ********************
  // external clock elastic buffer
  // ********************
  // bits are written on internal bit ticks and read on rising edges of
  // the external pin; the pin is sampled as an ordinary input
  reg [`ELASTIC_DEPTH-1:0] fifo_r;
  reg [3:0] wptr_r;
  reg [3:0] rptr_r;
  reg [4:0] fill_r;
  reg ext_d_r;
  reg started_r;
  reg out_bit_r;
  wire ext_rise = TX_CLOCK_PIN_I && !ext_d_r;
  // a full store drops the bit rather than overwrite unread data
  wire do_wr = ext_clk && TX_BIT_TICK && fill_r != 5'd16;
  wire do_rd = ext_clk && ext_rise && started_r && fill_r != 5'h00;

  always @(posedge REF_CLK) begin
    if (SRST || !ext_clk || !TRANSMIT_START_BIT) begin
      wptr_r <= 4'h0;
      rptr_r <= 4'h0;
      fill_r <= 5'h00;
      started_r <= 1'b0;
      ext_d_r <= 1'b0;
      out_bit_r <= 1'b0;
      fifo_r <= 16'h0000;
    end else begin
      ext_d_r <= TX_CLOCK_PIN_I;
      if (do_wr) begin
        fifo_r[wptr_r] <= TX_BIT_IN;
        wptr_r <= wptr_r + 4'h1;
      end
      if (do_rd) begin
        out_bit_r <= fifo_r[rptr_r];
        rptr_r <= rptr_r + 4'h1;
      end
      fill_r <= fill_r + {4'h0, do_wr} - {4'h0, do_rd};
      if (fill_r >= `EXT_START_BITS) begin
        started_r <= 1'b1;
      end
    end
  end

  // ********************
  // transmit data source
  // ********************
  assign TX_BIT_REQ = ext_clk ? do_wr : TX_BIT_TICK;
  wire tx_bit = ext_clk ? out_bit_r : TX_BIT_IN;

  // ********************
  // multi-function pins
  // ********************
  // card bus mode hands these pins over to upper address lines; the
  // pins then always drive, whatever the function bits hold
  function drive_of;
    input card;
    input fn;
    input en;
    begin
      if (card) begin
        drive_of = 1'b1;
      end else begin
        drive_of = fn && en;
      end
    end
  endfunction

  wire ant_drive = drive_of(CARD_BUS_MODE, ctrl_r[`ANT_FN_BIT], ANTENNA_PIN_ENABLE);
  wire txd_drive = drive_of(CARD_BUS_MODE, ctrl_r[`TXD_FN_BIT], TX_DATA_PIN_ENABLE);
  // tx command pin resolve
  // outside card bus mode, a receive command owner keeps the command pin released
  wire txcm_drive = drive_of(CARD_BUS_MODE, ctrl_r[`TXCM_FN_BIT],
    TX_COMMAND_PIN_ENABLE && !RECEIVE_COMMAND_ENABLE);

  reg ant_val;
  reg txd_val;
  reg txcm_val;

  always @* begin
    ant_val = 1'b0;
    txd_val = tx_bit;
    txcm_val = TX_CMD_VAL;
    if (CARD_BUS_MODE) begin
      ant_val = ALT_ADDR_HI[7];
      txd_val = ALT_ADDR_HI[7];
      txcm_val = ALT_ADDR_HI[5];
    end else if (ANTENNA_SWITCHING_ENABLE) begin
      ant_val = ANTENNA_SELECT_VAL;
    end
  end

  assign ANTENNA_SELECT_PIN_OE_N = !ant_drive;
  assign ANTENNA_SELECT_PIN_O = ant_val;
  assign TX_DATA_PIN_OE_N = !txd_drive;
  assign TX_DATA_PIN_O = txd_val;
  assign TX_COMMAND_PIN_OE_N = !txcm_drive;
  assign TX_COMMAND_PIN_O = txcm_val;

endmodule

// ---- verif/phy_model.sv ----
// radio-side model: supplies the external transmit clock
// assumes en is high only while a frame is sent on an input pin
`timescale 1ns/1ps
module phy_model #(
  parameter HALF = 81
) (
  input wire en,
  output reg tx_clock_pin
);
  initial tx_clock_pin = 1'b0;
  always #(HALF) tx_clock_pin <= en ? ~tx_clock_pin : 1'b0;
endmodule

// ---- verif/tai_pin_rate_sva.sv ----
// checker for the pin function and data rate block
// assumes it is bound to tai_pin_rate and sees only its ports
`timescale 1ns/1ps
`include "tai_pin_rate_regs.vh"
module pin_rate_chk #(
  parameter [7:0] REVISION = `REV_RST
) (
  input wire REF_CLK, input wire SRST, input wire [7:0] ADDR, input wire [7:0] WDATA,
  input wire WR, input wire RD, input wire [7:0] RDATA, input wire CARD_BUS_MODE,
  input wire ANTENNA_PIN_ENABLE, input wire TX_DATA_PIN_ENABLE, input wire TX_COMMAND_PIN_ENABLE,
  input wire RECEIVE_COMMAND_ENABLE, input wire ANTENNA_SELECT_PIN_OE_N,
  input wire TX_DATA_PIN_OE_N, input wire TX_COMMAND_PIN_OE_N, input wire TX_CLOCK_PIN_OE_N,
  input wire TX_BIT_TICK, input wire TX_BIT_REQ
);
  // shadow of the control register
  reg [7:0] ctl_r;
  always @(posedge REF_CLK) begin
    if (SRST) ctl_r <= `PFR_CTRL_RST;
    else if (WR && ADDR == `PFR_CTRL_IDX) ctl_r <= WDATA;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_rd_rev; RD && ADDR == `SILICON_REV_IDX; endsequence
  sequence s_rd_ctl; RD && ADDR == `PFR_CTRL_IDX; endsequence
  property p_rev; s_rd_rev |=> RDATA == REVISION; endproperty
  a_rev: assert property (p_rev) else $error("revision read");
  property p_ctl; s_rd_ctl |=> RDATA == {ctl_r[7:5], 1'b0, ctl_r[3:0]}; endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_txc; TX_CLOCK_PIN_OE_N == ctl_r[3]; endproperty
  a_txc: assert property (p_txc) else $error("txc direction");
  property p_tick; TX_BIT_TICK |=> !TX_BIT_TICK [*8]; endproperty
  a_tick: assert property (p_tick) else $error("bit tick spacing");
  property p_req; !ctl_r[3] |-> TX_BIT_REQ == TX_BIT_TICK; endproperty
  a_req: assert property (p_req) else $error("internal bit request");
  property p_ant;
    !CARD_BUS_MODE |-> ANTENNA_SELECT_PIN_OE_N == !(ctl_r[7] && ANTENNA_PIN_ENABLE); endproperty
  a_ant: assert property (p_ant) else $error("antenna oe");
  property p_txd;
    !CARD_BUS_MODE |-> TX_DATA_PIN_OE_N == !(ctl_r[6] && TX_DATA_PIN_ENABLE); endproperty
  a_txd: assert property (p_txd) else $error("tx data oe");
  property p_cmd; !CARD_BUS_MODE |-> TX_COMMAND_PIN_OE_N ==
    !(ctl_r[5] && TX_COMMAND_PIN_ENABLE && !RECEIVE_COMMAND_ENABLE); endproperty
  a_cmd: assert property (p_cmd) else $error("tx command oe");
endmodule
bind tai_pin_rate pin_rate_chk #(.REVISION(REVISION)) u_chk (.*);

// ---- verif/tb.sv ----
// testbench for the pin function and data rate block
// assumes phy_model supplies the external transmit clock
`timescale 1ns/1ps
`include "tai_pin_rate_regs.vh"
module tb;
  reg REF_CLK = 0, SRST = 1, WR = 0, RD = 0, CARD_BUS_MODE = 0, TX_CMD_VAL = 0;
  reg [7:0] ADDR = 0, WDATA = 0, ALT_ADDR_HI = 0;
  reg ANTENNA_PIN_ENABLE = 0, ANTENNA_SWITCHING_ENABLE = 0, ANTENNA_SELECT_VAL = 0;
  reg TX_DATA_PIN_ENABLE = 0, TX_COMMAND_PIN_ENABLE = 0, RECEIVE_COMMAND_ENABLE = 0;
  reg HIGH_INPUT_CLOCK_FLAG = 0, TRANSMIT_START_BIT = 0, TX_BIT_IN = 0;
  wire [7:0] RDATA;
  wire ANTENNA_SELECT_PIN_O, ANTENNA_SELECT_PIN_OE_N, TX_DATA_PIN_O, TX_DATA_PIN_OE_N;
  wire TX_COMMAND_PIN_O, TX_COMMAND_PIN_OE_N, TX_CLOCK_PIN_I, TX_CLOCK_PIN_O, phy_txc;
  wire TX_CLOCK_PIN_OE_N, PLL_OVS_TICK, TX_BIT_TICK, TX_BIT_REQ;
  integer n_mismatch = 0, checks_done = 0, i, n, po;
  // the clock pin carries whichever side is driving it
  assign TX_CLOCK_PIN_I = TX_CLOCK_PIN_OE_N ? phy_txc : TX_CLOCK_PIN_O;
  tai_pin_rate u_dut (.*);
  phy_model u_phy (.en(TRANSMIT_START_BIT & TX_CLOCK_PIN_OE_N), .tx_clock_pin(phy_txc));
  initial forever #4 REF_CLK = ~REF_CLK;
  // ********************
  // tasks
  // ********************
  task cyc; begin
    @(posedge REF_CLK);
    #1;
  end endtask
  task chk(input string nm, input [12:0] s, e); begin
    checks_done = checks_done + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  end endtask
  task wr(input [7:0] a, d); begin
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge REF_CLK);
    WR <= 0;
  end endtask
  task rc(input [7:0] a, e); begin
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge REF_CLK);
    RD <= 0;
    #1 chk("rdata", RDATA, e);
  end endtask
  // bounded wait for a bit tick, counting cycles and oversample ticks
  task wt; begin
    n = 0;
    po = 0;
    cyc;
    while (TX_BIT_TICK !== 1'b1 && n < 9000) begin
      po = po + PLL_OVS_TICK;
      n = n + 1;
      cyc;
    end
    po = po + PLL_OVS_TICK;
  end endtask
  // first ticks may still use the old ratio, so measure the third
  task rate(input hi, input [2:0] c, input [12:0] r); begin
    @(posedge REF_CLK);
    HIGH_INPUT_CLOCK_FLAG <= hi;
    wr(`PFR_CTRL_IDX, {5'h00, c});
    wt;
    wt;
    wt;
    chk("bit period", n + 1, r);
    chk("txc high", TX_CLOCK_PIN_O, 1'b1);
    chk("ovs per bit", po, `OVS_FACTOR);
  end endtask
  task summarize; begin
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  // ********************
  // tests
  // ********************
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    repeat (10) @(posedge REF_CLK);
    SRST <= 0;
    rc(`PFR_CTRL_IDX, `PFR_CTRL_RST);
    wr(`SILICON_REV_IDX, 8'h00);
    rc(`SILICON_REV_IDX, `REV_RST);
    rc(8'h10, 8'h00);
    wr(`PFR_CTRL_IDX, 8'he1);
    rc(`PFR_CTRL_IDX, 8'he1);
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge REF_CLK);
      {RECEIVE_COMMAND_ENABLE, TX_COMMAND_PIN_ENABLE, TX_DATA_PIN_ENABLE,
        ANTENNA_PIN_ENABLE} <= i[3:0];
      cyc;
      chk("pin oe", {ANTENNA_SELECT_PIN_OE_N, TX_DATA_PIN_OE_N, TX_COMMAND_PIN_OE_N},
        {i[0], i[1], i[2] & ~i[3]} ^ 3'h7);
    end
    chk("txc oe", TX_CLOCK_PIN_OE_N, 1'b0);
    @(posedge REF_CLK);
    ANTENNA_SWITCHING_ENABLE <= 1;
    ANTENNA_SELECT_VAL <= 1;
    TX_CMD_VAL <= 1;
    cyc;
    chk("pin out", {ANTENNA_SELECT_PIN_O, TX_DATA_PIN_O, TX_COMMAND_PIN_O}, 3'h5);
    @(posedge REF_CLK);
    CARD_BUS_MODE <= 1;
    ALT_ADDR_HI <= 8'h20;
    cyc;
    chk("bus oe", {ANTENNA_SELECT_PIN_OE_N, TX_DATA_PIN_OE_N, TX_COMMAND_PIN_OE_N},
      3'h0);
    chk("bus out", {ANTENNA_SELECT_PIN_O, TX_DATA_PIN_O, TX_COMMAND_PIN_O}, 3'h1);
    @(posedge REF_CLK);
    CARD_BUS_MODE <= 0;
    $display("test registers and pins done");
    rate(0, 3'h1, `DIV_20);
    rate(0, 3'h2, `DIV_40);
    rate(0, 3'h3, `DIV_80);
    rate(0, 3'h5, `DIV_200);
    rate(0, 3'h6, `DIV_2000);
    rate(1, 3'h1, `DIV_40);
    rate(1, 3'h2, `DIV_80);
    rate(1, 3'h3, `DIV_160);
    rate(1, 3'h5, `DIV_400);
    rate(1, 3'h6, `DIV_4000);
    rate(1, 3'h0, `DIV_20);
    $display("test rates done");
    // external clock: first data held back by the buffer fill
    wr(`PFR_CTRL_IDX, 8'h48);
    TX_BIT_IN <= 1;
    TRANSMIT_START_BIT <= 1;
    n = 0;
    po = 0;
    while (TX_DATA_PIN_O !== 1'b1 && po < 2000) begin
      cyc;
      po = po + 1;
      n = n + TX_BIT_REQ;
    end
    chk("bits before data", n >= 8 && n <= 10, 1'b1);
    TRANSMIT_START_BIT <= 0;
    $display("test external clock done");
    @(posedge REF_CLK);
    SRST <= 1;
    repeat (3) @(posedge REF_CLK);
    SRST <= 0;
    rc(`PFR_CTRL_IDX, `PFR_CTRL_RST);
    chk("txc oe after reset", TX_CLOCK_PIN_OE_N, 1'b1);
    $display("test mid reset done");
    summarize;
  end
endmodule
